//--- scd_pkg.sv
// constants, field layout and types for the sensor correction path
package scd_pkg;
    // coefficient store geometry
    localparam int BYTE_W = 8;
    localparam int NV_BYTES = 18;
    localparam int NV_BITS = NV_BYTES * BYTE_W;
    localparam int IDX_W = 5;
    localparam int SIG_IDX = 17;
    // field layout inside the store image
    localparam int GAIN_B_LSB = 0;
    localparam int GAIN_B_W = 12;
    localparam int OFF_B_LSB = 12;
    localparam int OFF_B_W = 12;
    localparam int OFF_SIGN_BIT = 24;
    localparam int TCG_LSB = 25;
    localparam int TCO_LSB = 33;
    localparam int SOT_LSB = 41;
    localparam int COEF_W = 8;
    localparam int SOT_SEL_LSB = 49;
    localparam int SOT_SEL_W = 2;
    localparam int GAIN_T_LSB = 51;
    localparam int OFF_T_LSB = 59;
    localparam int TSETL_LSB = 67;
    localparam int UPCLIP_LSB = 79;
    localparam int LOCLIP_LSB = 86;
    localparam int CLIP_W = 7;
    localparam int TRIM_LSB = 93;
    localparam int TRIM_W = 4;
    localparam int DIAG_LSB = 100;
    localparam int DIAG_W = 3;
    localparam int DIAG_LIMIT_BIT = 0;
    localparam int USER_LSB = 104;
    localparam int USER_W = 24;
    localparam logic [NV_BITS-1:0] NV_DEFAULT = (NV_BITS'(12'h400) << GAIN_B_LSB)
        | (NV_BITS'(8'h80) << GAIN_T_LSB) | (NV_BITS'(7'h7f) << UPCLIP_LSB);
    // data widths
    localparam int VAL_W = 14;
    localparam int TEMP_W = 12;
    localparam int TOUT_W = 8;
    localparam int DAC_W = 12;
    localparam logic [VAL_W-1:0] MAX_VAL = 14'h3fff;
    localparam logic [TEMP_W-1:0] MAX_TEMP = 12'hfff;
    // fixed-point scaling
    localparam int GAIN_B_FRAC = 10;
    localparam int GFAC_FRAC = 14;
    localparam int TCO_SH = 6;
    localparam int SOT_DT_SH = 8;
    localparam int SQ_SH = 20;
    localparam int GAIN_T_FRAC = 7;
    localparam logic signed [63:0] K125_NUM = 64'sh5;
    localparam int K125_SH = 2;
    // clip threshold padding
    localparam logic [1:0] CLIP_HI_TOP = 2'h3;
    localparam logic [4:0] CLIP_HI_PAD = 5'h1f;
    localparam logic [1:0] CLIP_LO_TOP = 2'h0;
    localparam logic [4:0] CLIP_LO_PAD = 5'h00;
    // reference trim
    localparam logic [TRIM_W-1:0] TRIM_FLIP = 4'h8;
    localparam logic [TRIM_W-1:0] TRIM_LOWEST = 4'h7;
    // signature
    localparam logic [BYTE_W-1:0] SIG_POLY = 8'h1d;
    localparam logic [BYTE_W-1:0] SIG_SEED = 8'hff;
    // bus map
    localparam int ADR_W = 8;
    localparam logic [ADR_W-1:0] ADR_RAW_SENSOR = 8'h00;
    localparam logic [ADR_W-1:0] ADR_RAW_TEMP = 8'h04;
    localparam logic [ADR_W-1:0] ADR_CMD = 8'h08;
    localparam logic [ADR_W-1:0] ADR_NV_WRITE = 8'h0c;
    localparam logic [ADR_W-1:0] ADR_NV_DUMP = 8'h10;
    localparam logic [ADR_W-1:0] ADR_STATUS = 8'h14;
    localparam logic [ADR_W-1:0] ADR_RESULT = 8'h18;
    localparam logic [ADR_W-1:0] ADR_TRIM = 8'h1c;
    localparam logic [ADR_W-1:0] ADR_CLIP = 8'h20;
    localparam int NVW_IDX_LSB = 8;
    localparam int RES_HI_LSB = 16;
    localparam logic [BYTE_W-1:0] CMD_DUMP = 8'h01;
    localparam logic [BYTE_W-1:0] CMD_CAL_TLOW = 8'h02;
    // timing
    localparam int unsigned PROG_TIME_US = 6000;
    localparam int unsigned SYS_CLK_MHZ = 25;
    // types
    typedef enum logic [1:0] {
        SOT_BRIDGE = 2'b00,
        SOT_OFFSET = 2'b01,
        SOT_GAIN = 2'b10
    } scd_sot_e;
    typedef enum logic [1:0] {
        NV_IDLE = 2'b00,
        NV_PROG = 2'b01,
        NV_SIGN = 2'b10
    } scd_nv_state_e;
endpackage

//--- scd_nvstore.sv
// coefficient store: byte array, timed programming, signature, dump shifter
`timescale 1ns/10ps
`default_nettype none
module scd_nvstore
    import scd_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = PROG_TIME_US * SYS_CLK_MHZ
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // program request
    input wire logic i_wr_req,
    input wire logic [NV_BITS-1:0] i_wr_img,
    input wire logic [NV_BITS-1:0] i_wr_mask,
    // dump shifter
    input wire logic i_dump_load,
    input wire logic i_dump_shift,
    output logic [BYTE_W-1:0] o_dump_byte,
    // contents and state
    output logic [NV_BITS-1:0] o_image,
    output logic o_busy
);
    logic [BYTE_W-1:0] mem [NV_BYTES];
    scd_nv_state_e state;
    logic [31:0] cnt;
    logic [IDX_W-1:0] sidx;
    logic [BYTE_W-1:0] sig;
    logic [NV_BITS-1:0] pend_img;
    logic [NV_BITS-1:0] pend_mask;
    logic [NV_BITS-1:0] dump_sr;
    logic commit;
    logic sig_wr;

    function automatic logic [BYTE_W-1:0] sig_step(input logic [BYTE_W-1:0] s,
                                                   input logic [BYTE_W-1:0] d);
        sig_step = {s[BYTE_W-2:0], 1'b0} ^ (s[BYTE_W-1] ? SIG_POLY : 8'h00) ^ d;
    endfunction

    assign commit = (state == NV_PROG) && (cnt == PROG_CYCLES - 1);
    assign sig_wr = (state == NV_SIGN) && (sidx == IDX_W'(SIG_IDX));
    assign o_busy = (state != NV_IDLE);
    assign o_dump_byte = dump_sr[BYTE_W-1:0];

    for (genvar g = 0; g < NV_BYTES; g++) begin : g_byte
        always_ff @(posedge i_sys_clk) begin
            if (i_reset) begin
                mem[g] <= NV_DEFAULT[g*BYTE_W +: BYTE_W];
            end else if (sig_wr && g == SIG_IDX) begin
                mem[g] <= sig;
            end else if (commit) begin
                mem[g] <= (mem[g] & ~pend_mask[g*BYTE_W +: BYTE_W])
                    | (pend_img[g*BYTE_W +: BYTE_W] & pend_mask[g*BYTE_W +: BYTE_W]);
            end
        end
        assign o_image[g*BYTE_W +: BYTE_W] = mem[g];
    end

    // signature is also rebuilt after reset so the stored byte always matches
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            state <= NV_SIGN;
            cnt <= 32'h0;
            sidx <= '0;
            sig <= SIG_SEED;
            pend_img <= '0;
            pend_mask <= '0;
        end else begin
            case (state)
                NV_IDLE: begin
                    if (i_wr_req) begin
                        state <= NV_PROG;
                        cnt <= 32'h0;
                        pend_img <= i_wr_img;
                        pend_mask <= i_wr_mask;
                    end
                end
                NV_PROG: begin
                    cnt <= cnt + 32'h1;
                    if (commit) begin
                        state <= NV_SIGN;
                        sidx <= '0;
                        sig <= SIG_SEED;
                    end
                end
                NV_SIGN: begin
                    if (sig_wr) begin
                        state <= NV_IDLE;
                    end else begin
                        sig <= sig_step(sig, mem[sidx]);
                        sidx <= sidx + 1'b1;
                    end
                end
                default: begin
                    state <= NV_IDLE;
                end
            endcase
        end
    end

    // each read moves the image on by one byte
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            dump_sr <= '0;
        end else if (i_dump_load) begin
            dump_sr <= o_image;
        end else if (i_dump_shift) begin
            dump_sr <= dump_sr >> BYTE_W;
        end
    end

    chk_sig_regen: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        commit |=> (state == NV_SIGN)[*8] ##11 (state == NV_IDLE))
        else $error("signature not rebuilt after programming");
    chk_dump_shift: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_dump_shift && !i_dump_load |=> dump_sr == ($past(dump_sr) >> BYTE_W))
        else $error("dump did not shift by one byte");
endmodule
`default_nettype wire

//--- scd_top.sv
// sensor correction path: arithmetic, clipping, outputs and register slave
//
// Local design decisions: the address map and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module scd_top
    import scd_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = PROG_TIME_US * SYS_CLK_MHZ
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [ADR_W-1:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic o_wb_ack,
    output logic [31:0] o_wb_dat,
    // raw conversions
    input wire logic i_sample_valid,
    input wire logic [VAL_W-1:0] i_raw_sensor,
    input wire logic [VAL_W-1:0] i_raw_temp,
    // corrected results
    output logic o_result_valid,
    output logic [VAL_W-1:0] o_value,
    output logic [DAC_W-1:0] o_dac_code,
    output logic [TOUT_W-1:0] o_dig_temp,
    // analog configuration and store state
    output logic o_limiter_en,
    output logic [TRIM_W-1:0] o_ref_trim,
    output logic o_nv_busy
);
    logic [NV_BITS-1:0] image;
    logic nv_busy;
    logic [BYTE_W-1:0] dump_byte;
    logic [VAL_W-1:0] raw_sensor_sample;
    logic [VAL_W-1:0] raw_temp_sample;
    logic go;
    logic [TEMP_W-1:0] t12;
    logic [TEMP_W-1:0] low_cal_temp_point;
    logic signed [TEMP_W:0] dt;
    logic [SOT_SEL_W-1:0] sot_sel;
    logic sot_off;
    logic sot_gain;
    logic signed [63:0] w_dt;
    logic signed [63:0] w_raw;
    logic signed [63:0] w_gainb;
    logic signed [63:0] w_offb;
    logic signed [63:0] w_tcg;
    logic signed [63:0] w_tco;
    logic signed [63:0] second_order_coef;
    logic signed [63:0] w_gaint;
    logic signed [63:0] w_offt;
    logic signed [63:0] w_sotdt;
    logic signed [63:0] off_drift;
    logic signed [63:0] gain_drift;
    logic signed [63:0] gfac;
    logic signed [63:0] corr;
    logic signed [63:0] intermediate_product;
    logic signed [63:0] second_order_output;
    logic signed [63:0] w_temp;
    logic [VAL_W-1:0] sat_val;
    logic [VAL_W-1:0] clip_val;
    logic [VAL_W-1:0] up_thr;
    logic [VAL_W-1:0] lo_thr;
    logic [TEMP_W-1:0] temp_val;
    logic [TEMP_W-1:0] temp_reg;
    logic [TRIM_W-1:0] trim_level;
    logic wb_req;
    logic wr_nv;
    logic wr_cal;
    logic wr_req;
    logic dump_load;
    logic dump_shift;
    logic read_raw_sensor_cmd;
    logic [IDX_W-1:0] wr_idx;
    logic [NV_BITS-1:0] wr_img;
    logic [NV_BITS-1:0] wr_mask;
    logic [31:0] rd_data;

    // coefficient store, including the user bytes at USER_LSB
    scd_nvstore #(
        .PROG_CYCLES(PROG_CYCLES)
    ) u_nvstore (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_wr_req(wr_req),
        .i_wr_img(wr_img),
        .i_wr_mask(wr_mask),
        .i_dump_load(dump_load),
        .i_dump_shift(dump_shift),
        .o_dump_byte(dump_byte),
        .o_image(image),
        .o_busy(nv_busy)
    );

    // capture one conversion pair
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            raw_sensor_sample <= '0;
            raw_temp_sample <= '0;
            go <= 1'b0;
        end else begin
            go <= i_sample_valid;
            if (i_sample_valid) begin
                raw_sensor_sample <= i_raw_sensor;
                raw_temp_sample <= i_raw_temp;
            end
        end
    end

    // coefficient fields
    assign t12 = raw_temp_sample[VAL_W-1 -: TEMP_W];
    assign low_cal_temp_point = image[TSETL_LSB +: TEMP_W];
    assign dt = $signed({1'b0, t12}) - $signed({1'b0, low_cal_temp_point});
    assign sot_sel = image[SOT_SEL_LSB +: SOT_SEL_W];
    assign sot_off = (sot_sel == SOT_OFFSET);
    assign sot_gain = (sot_sel == SOT_GAIN);
    assign up_thr = {CLIP_HI_TOP, image[UPCLIP_LSB +: CLIP_W], CLIP_HI_PAD};
    assign lo_thr = {CLIP_LO_TOP, image[LOCLIP_LSB +: CLIP_W], CLIP_LO_PAD};
    assign trim_level = ~(o_ref_trim ^ TRIM_FLIP);

    // 64-bit working width keeps every product free of wrap
    always_comb begin
        w_dt = 64'(dt);
        w_raw = 64'(raw_sensor_sample);
        w_gainb = 64'(image[GAIN_B_LSB +: GAIN_B_W]);
        w_offb = 64'(image[OFF_B_LSB +: OFF_B_W]);
        w_tcg = 64'($signed(image[TCG_LSB +: COEF_W]));
        w_tco = 64'($signed(image[TCO_LSB +: COEF_W]));
        second_order_coef = 64'($signed(image[SOT_LSB +: COEF_W]));
        w_gaint = 64'(image[GAIN_T_LSB +: COEF_W]);
        w_offt = 64'($signed(image[OFF_T_LSB +: COEF_W]));
        w_sotdt = (second_order_coef * w_dt) >>> SOT_DT_SH;
        if (sot_off) begin
            off_drift = (w_dt * (w_sotdt + w_tco)) >>> TCO_SH;
        end else begin
            off_drift = (w_dt * w_tco) >>> TCO_SH;
        end
        if (sot_gain) begin
            gain_drift = w_dt * (w_sotdt + w_tcg);
        end else begin
            gain_drift = w_dt * w_tcg;
        end
        gfac = (64'sh1 <<< GFAC_FRAC) + gain_drift;
        if (image[OFF_SIGN_BIT]) begin
            corr = w_raw + w_offb + off_drift;
        end else begin
            corr = w_raw - w_offb + off_drift;
        end
        intermediate_product = ((((w_gainb * gfac) >>> GFAC_FRAC) * corr)
            >>> GAIN_B_FRAC);
        // squaring in bridge mode and for the unused select code 2'b11, never stacked on a drift mode
        if (!sot_off && !sot_gain) begin
            second_order_output = ((intermediate_product * K125_NUM) >>> K125_SH)
                + ((second_order_coef * intermediate_product * intermediate_product)
                >>> SQ_SH);
        end else begin
            second_order_output = intermediate_product;
        end
        if (second_order_output < 0) begin
            sat_val = '0;
        end else if (second_order_output > $signed(64'(MAX_VAL))) begin
            sat_val = MAX_VAL;
        end else begin
            sat_val = second_order_output[VAL_W-1:0];
        end
        if (sat_val > up_thr) begin
            clip_val = up_thr;
        end else if (sat_val < lo_thr) begin
            clip_val = lo_thr;
        end else begin
            clip_val = sat_val;
        end
        // signed cast keeps a negative offset from turning the sum unsigned
        w_temp = (w_gaint * ($signed(64'(t12)) + w_offt)) >>> GAIN_T_FRAC;
        if (w_temp < 0) begin
            temp_val = '0;
        end else if (w_temp > $signed(64'(MAX_TEMP))) begin
            temp_val = MAX_TEMP;
        end else begin
            temp_val = w_temp[TEMP_W-1:0];
        end
    end

    // result registers, two edges after the sample strobe
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_result_valid <= 1'b0;
            o_value <= '0;
            o_dac_code <= '0;
            o_dig_temp <= '0;
            temp_reg <= '0;
        end else begin
            o_result_valid <= go;
            if (go) begin
                o_value <= clip_val;
                o_dac_code <= clip_val[VAL_W-1 -: DAC_W];
                temp_reg <= temp_val;
                o_dig_temp <= temp_val[TEMP_W-1 -: TOUT_W];
            end
        end
    end

    // configuration pins follow the store image
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_limiter_en <= 1'b0;
            o_ref_trim <= '0;
            o_nv_busy <= 1'b0;
        end else begin
            o_limiter_en <= image[DIAG_LSB + DIAG_LIMIT_BIT];
            o_ref_trim <= image[TRIM_LSB +: TRIM_W];
            o_nv_busy <= nv_busy;
        end
    end

    // command decode
    assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
    assign wr_idx = i_wb_dat[NVW_IDX_LSB +: IDX_W];
    assign wr_nv = wb_req && i_wb_we && i_wb_sel[0] && i_wb_sel[1]
        && (i_wb_adr == ADR_NV_WRITE) && (wr_idx < IDX_W'(SIG_IDX));
    assign wr_cal = wb_req && i_wb_we && i_wb_sel[0] && (i_wb_adr == ADR_CMD)
        && (i_wb_dat[BYTE_W-1:0] == CMD_CAL_TLOW);
    // a busy store silently drops writes and dump reloads
    assign wr_req = (wr_nv || wr_cal) && !nv_busy;
    assign dump_load = wb_req && i_wb_we && i_wb_sel[0] && (i_wb_adr == ADR_CMD)
        && (i_wb_dat[BYTE_W-1:0] == CMD_DUMP) && !nv_busy;
    assign dump_shift = wb_req && !i_wb_we && (i_wb_adr == ADR_NV_DUMP);
    assign read_raw_sensor_cmd = wb_req && !i_wb_we && (i_wb_adr == ADR_RAW_SENSOR);

    always_comb begin
        if (wr_cal) begin
            wr_img = NV_BITS'(t12) << TSETL_LSB;
            wr_mask = NV_BITS'({TEMP_W{1'b1}}) << TSETL_LSB;
        end else begin
            wr_img = NV_BITS'(i_wb_dat[BYTE_W-1:0]) << (wr_idx * BYTE_W);
            wr_mask = NV_BITS'({BYTE_W{1'b1}}) << (wr_idx * BYTE_W);
        end
    end

    always_comb begin
        case (i_wb_adr)
            ADR_RAW_SENSOR: rd_data = 32'(raw_sensor_sample);
            ADR_RAW_TEMP: rd_data = 32'(raw_temp_sample);
            ADR_NV_DUMP: rd_data = 32'(dump_byte);
            ADR_STATUS: rd_data = 32'(nv_busy);
            ADR_RESULT: rd_data = 32'(o_value) | (32'(temp_reg) << RES_HI_LSB);
            ADR_TRIM: rd_data = 32'({trim_level, o_ref_trim});
            ADR_CLIP: rd_data = 32'(lo_thr) | (32'(up_thr) << RES_HI_LSB);
            default: rd_data = 32'h0;
        endcase
    end

    // single-wait-state slave; unmapped addresses ack with zero
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0;
        end else begin
            o_wb_ack <= wb_req;
            if (wb_req) begin
                o_wb_dat <= i_wb_we ? 32'h0 : rd_data;
            end
        end
    end

    chk_ack_single: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        o_wb_ack |=> !o_wb_ack)
        else $error("ack held longer than one cycle");
    chk_ack_timing: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        wb_req |=> o_wb_ack)
        else $error("request not answered next cycle");
    chk_result_latency: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_sample_valid |-> ##2 o_result_valid)
        else $error("result not produced two cycles after sample");
    chk_clip_bounds: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        o_result_valid |-> (o_value <= up_thr) && (o_value >= lo_thr))
        else $error("output outside clip thresholds");
    chk_clip_pass: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        go && (sat_val <= up_thr) && (sat_val >= lo_thr) |=> o_value == $past(sat_val))
        else $error("in-range value altered");
    chk_sat_low: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        go && (second_order_output < 0) |=> o_value == $past(lo_thr))
        else $error("negative result not saturated");
    chk_dac_msbs: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        o_result_valid |-> o_dac_code == o_value[VAL_W-1 -: DAC_W])
        else $error("dac code not top bits of value");
    chk_temp_msbs: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        o_result_valid |-> o_dig_temp == temp_reg[TEMP_W-1 -: TOUT_W])
        else $error("digital temperature not top bits");
    chk_busy_hold: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        wr_req |=> nv_busy[*8] ##1 o_nv_busy)
        else $error("store not held busy after write");
    chk_trim_order: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (o_ref_trim == TRIM_LOWEST) |-> (trim_level == '0))
        else $error("lowest trim code not lowest level");
    chk_raw_read: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        read_raw_sensor_cmd |=> o_wb_dat[VAL_W-1:0] == $past(raw_sensor_sample))
        else $error("raw sensor read returned wrong sample");
endmodule
`default_nettype wire

//--- scd_adc_model.sv
// adc conversion source feeding raw samples to the correction path
`timescale 1ns/10ps
`default_nettype none
module scd_adc_model
    import scd_pkg::*;
(
    // clock
    input wire logic i_sys_clk,
    // request from bench
    input wire logic i_go,
    input wire logic [VAL_W-1:0] i_sensor,
    input wire logic [VAL_W-1:0] i_temp,
    // conversion outputs
    output logic o_valid,
    output logic [VAL_W-1:0] o_raw_sensor,
    output logic [VAL_W-1:0] o_raw_temp
);
    initial begin
        o_valid = 1'b0;
        o_raw_sensor = '0;
        o_raw_temp = '0;
    end
    // stale data toggles so it is never mistaken for a held result
    always @(posedge i_sys_clk) begin
        o_valid <= i_go;
        o_raw_sensor <= i_go ? i_sensor : ~o_raw_sensor;
        o_raw_temp <= i_go ? i_temp : ~o_raw_temp;
    end
endmodule
`default_nettype wire

//--- test_sensor_correction_dsp.sv
// self-checking bench for the sensor correction path
`timescale 1ns/10ps
`default_nettype none
module test_sensor_correction_dsp
    import scd_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0;
    logic [7:0] adr = '0;
    logic [31:0] wdat = '0, q, rdat;
    logic [3:0] sel = '0;
    logic [13:0] s_in = '0, t_in = '0, rs, rt, val;
    logic ack, sv, rv, lim, busy;
    logic [11:0] dac;
    logic [7:0] dtemp;
    logic [3:0] trim;
    int err_total = 0, comparisons = 0, cycles = 0;
    always #20 clk = ~clk;
    scd_adc_model adc (.i_sys_clk(clk), .i_go(go), .i_sensor(s_in), .i_temp(t_in),
        .o_valid(sv), .o_raw_sensor(rs), .o_raw_temp(rt));
    scd_top #(.PROG_CYCLES(20)) uut (.i_sys_clk(clk), .i_reset(rst), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
        .o_wb_ack(ack), .o_wb_dat(rdat), .i_sample_valid(sv), .i_raw_sensor(rs),
        .i_raw_temp(rt), .o_result_valid(rv), .o_value(val), .o_dac_code(dac),
        .o_dig_temp(dtemp), .o_limiter_en(lim), .o_ref_trim(trim), .o_nv_busy(busy));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ceiling well above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wait_idle();
        q = 32'h1;
        while (q[0] !== 1'b0) wb(1'b0, ADR_STATUS, 32'h0);
    endtask
    task automatic nvw(input logic [4:0] i, input logic [7:0] b);
        wb(1'b1, ADR_NV_WRITE, {19'h0, i, b});
        wait_idle();
    endtask
    task automatic sample(input logic [13:0] s, input logic [13:0] t,
        input logic [13:0] ev, input logic [7:0] et);
        int n;
        @(posedge clk);
        go <= 1'b1;
        s_in <= s;
        t_in <= t;
        @(posedge clk);
        go <= 1'b0;
        n = 0;
        while (rv !== 1'b1 && n < 8) begin
            @(posedge clk);
            n++;
        end
        chk("result_valid", rv, 1);
        chk("value", val, ev);
        chk("dac_code", dac, ev[13:2]);
        chk("dig_temp", dtemp, et);
    endtask
    task automatic t_reset();
        repeat (2) @(posedge clk);
        chk("busy_after_reset", busy, 1);
        wait_idle();
        chk("limiter", lim, 0);
        wb(1'b0, ADR_TRIM, 32'h0);
        chk("trim_reg", q, 32'h70);
        $display("test reset done");
    endtask
    task automatic t_math();
        sample(14'h0800, 14'h1230, 14'h0a00, 8'h48);
        wb(1'b0, ADR_RAW_SENSOR, 32'h0);
        chk("raw_sensor", q, 32'h800);
        sample(14'h3800, 14'h0000, 14'h3fff, 8'h00);
        $display("test math done");
    endtask
    task automatic t_clip();
        // upper field drops to 1, lower field rises to 1
        nvw(5'd10, 8'h40);
        wb(1'b0, ADR_CLIP, 32'h0);
        chk("clip_reg", q, 32'h303f0020);
        sample(14'h3000, 14'h0000, 14'h303f, 8'h00);
        sample(14'h0000, 14'h0000, 14'h0020, 8'h00);
        $display("test clip done");
    endtask
    task automatic t_trim();
        nvw(5'd12, 8'h11);
        chk("ref_trim", trim, 4'h8);
        chk("limiter", lim, 1);
        wb(1'b0, ADR_TRIM, 32'h0);
        chk("trim_reg", q, 32'hf8);
        nvw(5'd11, 8'he0);
        nvw(5'd12, 8'h10);
        wb(1'b0, ADR_TRIM, 32'h0);
        chk("trim_lowest", q, 32'h07);
        $display("test trim done");
    endtask
    task automatic t_modes();
        sample(14'h0800, 14'h0400, 14'h0a00, 8'h10);
        wb(1'b1, ADR_CMD, {24'h0, CMD_CAL_TLOW});
        wait_idle();
        nvw(5'd5, 8'h02);
        sample(14'h0800, 14'h0400, 14'h0a04, 8'h10);
        nvw(5'd6, 8'h02);
        sample(14'h0800, 14'h0800, 14'h0804, 8'h20);
        nvw(5'd6, 8'h04);
        sample(14'h0800, 14'h0800, 14'h0820, 8'h20);
        nvw(5'd2, 8'h01);
        sample(14'h0800, 14'h0800, 14'h080f, 8'h20);
        sample(14'h0000, 14'h0800, 14'h0020, 8'h20);
        nvw(5'd3, 8'h01);
        sample(14'h0800, 14'h0800, 14'h0830, 8'h20);
        $display("test modes done");
    endtask
    task automatic t_dump();
        wb(1'b1, ADR_NV_WRITE, 32'h0055);
        wb(1'b1, ADR_NV_WRITE, 32'h0199);
        wait_idle();
        nvw(5'd13, 8'ha5);
        wb(1'b1, ADR_CMD, {24'h0, CMD_DUMP});
        wb(1'b0, ADR_NV_DUMP, 32'h0);
        chk("dump_byte0", q, 32'h55);
        wb(1'b0, ADR_NV_DUMP, 32'h0);
        chk("dump_byte1", q, 32'h04);
        repeat (11) wb(1'b0, ADR_NV_DUMP, 32'h0);
        wb(1'b0, ADR_NV_DUMP, 32'h0);
        chk("user_byte", q, 32'ha5);
        wb(1'b0, 8'h30, 32'h0);
        chk("unmapped", q, 32'h0);
        $display("test dump done");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_math();
        t_clip();
        t_trim();
        t_modes();
        t_dump();
        tally_and_finish();
    end
endmodule
`default_nettype wire
